// *** smu_master.sv ***
// Register-driven serial master: register file, trigger select, shift engine
// How it works
// - The bits received in the last transfer land in a 64-bit read-only receive register, upper bits zero.
// - A 64-bit write-only transmit register holds the bits shifted out on the next transfer.
// - With trigger select zero, writing the top byte implied by the frame size starts a transfer.
// - A two-bit field picks which of four slave selects is driven low during a transfer.
// - Config bit 3 keeps the active slave select low after the transfer so longer frames can chain.
// - A three-bit field picks the start source: write, PWM start, centre, mark A, mark B, A or B, reserved, soft.
// - With trigger select seven, setting config bit 15 runs exactly one transfer.
// - State bit 0 reads one when the last transfer is done, even while a full FIFO holds off the next start; other bits read zero.
// - The six-bit size field gives a frame of field plus one bits.
// - Each half period of the serial clock lasts two plus the bit period setting base cycles.
module smu_master
  import smu_pkg::*;
(
  input  wire logic                  clk_sys_in,          // System clock
  input  wire logic                  reset_in,            // Async reset, high
  input  wire logic                  ce_in,               // Clock enable, freezes all state
  input  wire logic [SMU_ADDR_W-1:0] reg_addr_in,         // Register index
  input  wire logic                  reg_wr_in,           // Write strobe
  input  wire logic                  reg_rd_in,           // Read strobe
  input  wire logic [7:0]            reg_be_in,           // Byte enables
  input  wire logic [SMU_DATA_W-1:0] reg_wdata_in,        // Write data
  output logic      [SMU_DATA_W-1:0] reg_rdata_out,       // Read data
  output logic                       reg_rvalid_out,      // Read data valid pulse
  input  wire logic                  pwm_cycle_start_in,  // PWM cycle start event
  input  wire logic                  pwm_cycle_centre_in, // PWM cycle centre event
  input  wire logic                  pwm_mark_a_in,       // PWM mark A event
  input  wire logic                  pwm_mark_b_in,       // PWM mark B event
  input  wire logic                  miso_in,             // Serial data in
  output logic                       sclk_out,            // Serial clock
  output logic                       mosi_out,            // Serial data out
  output logic      [SMU_SEL_N-1:0]  ss_n_out,            // Slave selects, low active
  output logic                       rx_stream_valid_out, // Received word valid
  output logic      [SMU_DATA_W-1:0] rx_stream_data_out,  // Received word
  input  wire logic                  rx_stream_ready_in   // Received word taken
);
  typedef struct packed {
    smu_state_t            st;
    logic [15:0]           cfg;
    logic [5:0]            size;
    logic [7:0]            period;
    logic [SMU_DATA_W-1:0] tx;
    logic [SMU_DATA_W-1:0] shadow;
    logic [SMU_DATA_W-1:0] rx;
    logic                  done;
    logic                  keep_hold;
    logic [1:0]            sel;
    logic                  lsb;
    logic                  cpha;
    logic                  sclk;
    logic                  mosi;
    logic [SMU_SEL_N-1:0]  ss_n;
    logic [8:0]            half_cnt;
    logic [6:0]            edge_cnt;
    logic [5:0]            bit_idx;
    logic [SMU_DATA_W-1:0] rdata;
    logic                  rvalid;
    logic                  push;
    logic                  out_valid;
    logic [SMU_DATA_W-1:0] out_data;
  } smu_master_t;

  smu_master_t r_reg;
  smu_master_t r_next;

  smu_stream_if #(.W(SMU_DATA_W)) rxq ();

  smu_fifo #(.W(SMU_DATA_W), .DEPTH(SMU_FIFO_DEPTH)) u_rx_fifo (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .port       (rxq.fifo_side)
  );

  logic       pop_take;
  logic [2:0] trig;
  logic       trig_hit;
  logic       write_hit;
  logic       start;
  logic [6:0] last_edge;
  logic       lead;

  assign rxq.push_valid = r_reg.push;
  assign rxq.push_data  = r_reg.rx;
  assign pop_take       = !r_reg.out_valid || rx_stream_ready_in;
  assign rxq.pop_ready  = pop_take;

  assign trig      = r_reg.cfg[SMU_CFG_TRIG_LO +: 3];
  assign write_hit = reg_wr_in && (reg_addr_in == SMU_REG_TX) && reg_be_in[r_reg.size[5:3]];
  assign last_edge = {r_reg.size, 1'b1};
  assign lead      = !r_reg.edge_cnt[0];

  always_comb begin
    case (trig)
      SMU_TRIG_WRITE:  trig_hit = write_hit;
      SMU_TRIG_START:  trig_hit = pwm_cycle_start_in;
      SMU_TRIG_CENTRE: trig_hit = pwm_cycle_centre_in;
      SMU_TRIG_MARK_A: trig_hit = pwm_mark_a_in;
      SMU_TRIG_MARK_B: trig_hit = pwm_mark_b_in;
      SMU_TRIG_MARKAB: trig_hit = pwm_mark_a_in | pwm_mark_b_in;
      SMU_TRIG_SOFT:   trig_hit = r_reg.cfg[SMU_CFG_ONESHOT];
      default:         trig_hit = 1'b0;
    endcase
  end

  // A finished word waits in the FIFO; a full FIFO holds off the next start
  assign start = (r_reg.st == SMU_IDLE) && r_reg.done && trig_hit && rxq.push_ready;

  always_comb begin
    r_next        = r_reg;
    r_next.push   = 1'b0;
    r_next.rvalid = 1'b0;

    // One-shot is cleared by the start; a fresh write below wins over it
    if (start && trig == SMU_TRIG_SOFT) begin
      r_next.cfg[SMU_CFG_ONESHOT] = 1'b0;
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        SMU_REG_TX: begin
          for (int b = 0; b < 8; b++) begin
            if (reg_be_in[b]) begin
              r_next.tx[8*b +: 8] = reg_wdata_in[8*b +: 8];
            end
          end
        end
        SMU_REG_CFG: begin
          if (reg_be_in[0]) begin
            r_next.cfg[7:0] = reg_wdata_in[7:0];
          end
          if (reg_be_in[1]) begin
            r_next.cfg[15:8] = reg_wdata_in[15:8];
          end
        end
        SMU_REG_SIZE: begin
          if (reg_be_in[0]) begin
            r_next.size = reg_wdata_in[5:0];
          end
        end
        SMU_REG_PERIOD: begin
          if (reg_be_in[0]) begin
            r_next.period = reg_wdata_in[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    if (reg_rd_in) begin
      r_next.rvalid = 1'b1;
      case (reg_addr_in)
        SMU_REG_RX:    r_next.rdata = r_reg.rx;
        SMU_REG_CFG:   r_next.rdata = {48'h0000_0000_0000, r_reg.cfg};
        SMU_REG_STATE: r_next.rdata = {63'h0, r_reg.done};
        default:       r_next.rdata = 64'h0000_0000_0000_0000;
      endcase
    end

    case (r_reg.st)
      SMU_IDLE: begin
        r_next.sclk = r_reg.cfg[SMU_CFG_CPOL];
        if (start) begin
          r_next.st       = SMU_SHIFT;
          r_next.done     = 1'b0;
          r_next.sel      = r_reg.cfg[SMU_CFG_SEL_LO +: 2];
          r_next.lsb      = r_reg.cfg[SMU_CFG_LSB];
          r_next.cpha     = r_reg.cfg[SMU_CFG_CPHA];
          r_next.bit_idx  = r_reg.cfg[SMU_CFG_LSB] ? 6'h00 : r_reg.size;
          r_next.mosi     = r_next.tx[r_next.bit_idx];
          r_next.shadow   = 64'h0000_0000_0000_0000;
          r_next.edge_cnt = 7'h00;
          r_next.half_cnt = SMU_HALF_BASE + {1'b0, r_reg.period};
        end
      end
      SMU_SHIFT: begin
        if (r_reg.half_cnt != 9'h001) begin
          r_next.half_cnt = r_reg.half_cnt - 9'h001;
        end else begin
          r_next.half_cnt = SMU_HALF_BASE + {1'b0, r_reg.period};
          r_next.sclk     = !r_reg.sclk;
          r_next.edge_cnt = r_reg.edge_cnt + 7'h01;
          if (lead ^ r_reg.cpha) begin
            // Sample edge: store the bit, then step to the next one
            r_next.shadow[r_reg.bit_idx] = miso_in;
            r_next.bit_idx = r_reg.lsb ? r_reg.bit_idx + 6'h01 : r_reg.bit_idx - 6'h01;
          end else begin
            r_next.mosi = r_reg.tx[r_reg.bit_idx];
          end
          if (r_reg.edge_cnt == last_edge) begin
            r_next.st = SMU_TAIL;
          end
        end
      end
      SMU_TAIL: begin
        if (r_reg.half_cnt != 9'h001) begin
          r_next.half_cnt = r_reg.half_cnt - 9'h001;
        end else begin
          r_next.st        = SMU_IDLE;
          r_next.rx        = r_reg.shadow;
          r_next.done      = 1'b1;
          r_next.push      = 1'b1;
          r_next.keep_hold = r_reg.cfg[SMU_CFG_KEEP];
        end
      end
      default: begin
        r_next.st = SMU_IDLE;
      end
    endcase

    // Clearing the keep bit releases a held select at once
    if (!r_next.cfg[SMU_CFG_KEEP]) begin
      r_next.keep_hold = 1'b0;
    end
    r_next.ss_n = {SMU_SEL_N{1'b1}};
    if (r_next.st != SMU_IDLE || r_next.keep_hold) begin
      r_next.ss_n[r_next.sel] = 1'b0;
    end

    if (pop_take) begin
      r_next.out_valid = rxq.pop_valid;
      r_next.out_data  = rxq.pop_data;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      r_reg        <= '0;
      r_reg.st     <= SMU_IDLE;
      r_reg.cfg    <= SMU_CFG_RESET;
      r_reg.size   <= SMU_SIZE_RESET;
      r_reg.period <= SMU_PERIOD_RESET;
      r_reg.done   <= 1'b1;
      r_reg.ss_n   <= {SMU_SEL_N{1'b1}};
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata_out       = r_reg.rdata;
  assign reg_rvalid_out      = r_reg.rvalid;
  assign sclk_out            = r_reg.sclk;
  assign mosi_out            = r_reg.mosi;
  assign ss_n_out            = r_reg.ss_n;
  assign rx_stream_valid_out = r_reg.out_valid;
  assign rx_stream_data_out  = r_reg.out_data;
endmodule // smu_master

// *** smu_pkg.sv ***
// Register map, field layout and constants of the serial master unit
package smu_pkg;
  localparam int unsigned SMU_ADDR_W      = 5;
  localparam int unsigned SMU_DATA_W      = 64;
  localparam int unsigned SMU_SEL_N       = 4;
  localparam int unsigned SMU_FIFO_DEPTH  = 8;

  localparam logic [4:0]  SMU_REG_RX      = 5'h06;
  localparam logic [4:0]  SMU_REG_TX      = 5'h07;
  localparam logic [4:0]  SMU_REG_CFG     = 5'h08;
  localparam logic [4:0]  SMU_REG_STATE   = 5'h09;
  localparam logic [4:0]  SMU_REG_SIZE    = 5'h0a;
  localparam logic [4:0]  SMU_REG_PERIOD  = 5'h0b;

  localparam int unsigned SMU_CFG_SEL_LO  = 0;
  localparam int unsigned SMU_CFG_KEEP    = 3;
  localparam int unsigned SMU_CFG_LSB     = 4;
  localparam int unsigned SMU_CFG_CPHA    = 5;
  localparam int unsigned SMU_CFG_CPOL    = 6;
  localparam int unsigned SMU_CFG_TRIG_LO = 8;
  localparam int unsigned SMU_CFG_ONESHOT = 15;
  localparam int unsigned SMU_STATE_DONE  = 0;

  localparam logic [15:0] SMU_CFG_RESET    = 16'h0000;
  localparam logic [5:0]  SMU_SIZE_RESET   = 6'h07;
  localparam logic [7:0]  SMU_PERIOD_RESET = 8'h00;
  localparam logic [8:0]  SMU_HALF_BASE    = 9'h002;

  localparam logic [2:0]  SMU_TRIG_WRITE  = 3'h0;
  localparam logic [2:0]  SMU_TRIG_START  = 3'h1;
  localparam logic [2:0]  SMU_TRIG_CENTRE = 3'h2;
  localparam logic [2:0]  SMU_TRIG_MARK_A = 3'h3;
  localparam logic [2:0]  SMU_TRIG_MARK_B = 3'h4;
  localparam logic [2:0]  SMU_TRIG_MARKAB = 3'h5;
  localparam logic [2:0]  SMU_TRIG_SOFT   = 3'h7;

  typedef enum logic [1:0] {
    SMU_IDLE  = 2'b00,
    SMU_SHIFT = 2'b01,
    SMU_TAIL  = 2'b10
  } smu_state_t;
endpackage

// *** smu_stream_if.sv ***
// Push and pop handshake between the shift engine and the receive FIFO
interface smu_stream_if #(parameter int unsigned W = 64);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport fifo_side (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user_side (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

// *** smu_fifo.sv ***
// Receive word FIFO with valid/ready on both sides
module smu_fifo #(
  parameter int unsigned W     = 64,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic          clk_sys_in, // System clock
  input  wire logic          reset_in,   // Async reset, high
  input  wire logic          ce_in,      // Clock enable
  smu_stream_if.fifo_side    port        // Push and pop side
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
    $error("smu_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } smu_fifo_t;

  smu_fifo_t f_reg;
  smu_fifo_t f_next;
  logic      do_push;
  logic      do_pop;

  assign port.push_ready = (f_reg.cnt != DEPTH[AW:0]);
  assign port.pop_valid  = (f_reg.cnt != '0);
  assign port.pop_data   = f_reg.mem[f_reg.rp];
  assign do_push         = port.push_valid & port.push_ready;
  assign do_pop          = port.pop_ready & port.pop_valid;

  always_comb begin
    f_next = f_reg;
    if (do_push) begin
      f_next.mem[f_reg.wp] = port.push_data;
      f_next.wp            = f_reg.wp + 1'b1;
    end
    if (do_pop) begin
      f_next.rp = f_reg.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      f_next.cnt = f_reg.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      f_next.cnt = f_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      f_reg <= '0;
    end else if (ce_in) begin
      f_reg <= f_next;
    end
  end
endmodule // smu_fifo

// *** smu_checker.sv ***
// Port assertions for the serial master unit
module smu_checker
  import smu_pkg::*;
(
  input wire logic                  clk_sys_in,          // Clock
  input wire logic                  reset_in,            // Reset
  input wire logic                  ce_in,               // Enable
  input wire logic [SMU_ADDR_W-1:0] reg_addr_in,         // Index
  input wire logic                  reg_wr_in,           // Write
  input wire logic                  reg_rd_in,           // Read
  input wire logic [SMU_DATA_W-1:0] reg_wdata_in,        // Write data
  input wire logic [SMU_DATA_W-1:0] reg_rdata_out,       // Read data
  input wire logic                  reg_rvalid_out,      // Read valid
  input wire logic                  sclk_out,            // Serial clock
  input wire logic                  mosi_out,            // Serial out
  input wire logic [SMU_SEL_N-1:0]  ss_n_out,            // Selects
  input wire logic                  rx_stream_valid_out, // Word valid
  input wire logic [SMU_DATA_W-1:0] rx_stream_data_out,  // Word
  input wire logic                  rx_stream_ready_in   // Word taken
);
  logic [15:0] cfg_reg;
  logic [7:0]  per_reg;
  logic        sclk_reg;
  logic [9:0]  gap_reg;
  logic [9:0]  half;
  logic        wr_ok;
  assign half = 10'(per_reg) + 10'h002;
  assign wr_ok = ce_in && reg_wr_in;
  // Shadow of config and period, cycles since the last clock change
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_reg  <= SMU_CFG_RESET;
      per_reg  <= SMU_PERIOD_RESET;
      sclk_reg <= 1'b0;
      gap_reg  <= 10'h3ff;
    end else begin
      if (wr_ok && reg_addr_in == SMU_REG_CFG) cfg_reg <= reg_wdata_in[15:0];
      if (wr_ok && reg_addr_in == SMU_REG_PERIOD) per_reg <= reg_wdata_in[7:0];
      sclk_reg <= sclk_out;
      gap_reg  <= (sclk_out != sclk_reg) ? 10'h001 : gap_reg + {9'h000, gap_reg != 10'h3ff};
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_read; ce_in && reg_rd_in; endsequence
  sequence s_clk_edge; sclk_out != sclk_reg && ss_n_out != 4'hf; endsequence
  property p_read_answer; s_read |=> reg_rvalid_out; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_state_upper; s_read ##0 reg_addr_in == SMU_REG_STATE |=> reg_rdata_out[63:1] == 63'h0; endproperty
  a_state_upper: assert property (p_state_upper) else $error("state upper bits set");
  property p_tx_hidden; s_read ##0 reg_addr_in == SMU_REG_TX |=> reg_rdata_out == 64'h0; endproperty
  a_tx_hidden: assert property (p_tx_hidden) else $error("transmit word readable");
  property p_one_select; $onehot0(~ss_n_out); endproperty
  a_one_select: assert property (p_one_select) else $error("several selects low");
  property p_select_match; ss_n_out != 4'hf |-> ss_n_out[cfg_reg[1:0]] == 1'b0; endproperty
  a_select_match: assert property (p_select_match) else $error("wrong select low");
  property p_idle_clock; ss_n_out == 4'hf && $stable(cfg_reg) |-> sclk_out == cfg_reg[6]; endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("idle clock level wrong");
  property p_half; s_clk_edge |-> gap_reg == half || gap_reg > half + 10'h001; endproperty
  a_half: assert property (p_half) else $error("half period wrong");
  property p_sample_stable; s_clk_edge ##0 (sclk_out ^ cfg_reg[6]) != cfg_reg[5] |-> $stable(mosi_out); endproperty
  a_sample_stable: assert property (p_sample_stable) else $error("data moved on sample edge");
  property p_stream_hold; rx_stream_valid_out && !rx_stream_ready_in |=> rx_stream_valid_out && $stable(rx_stream_data_out); endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream word dropped");
endmodule // smu_checker

bind smu_master smu_checker u_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .sclk_out(sclk_out), .mosi_out(mosi_out),
  .ss_n_out(ss_n_out), .rx_stream_valid_out(rx_stream_valid_out), .rx_stream_data_out(rx_stream_data_out),
  .rx_stream_ready_in(rx_stream_ready_in));

// *** smu_slave_model.sv ***
// Echoing slave that records the bits it samples
module smu_slave_model (
  input  wire logic       clk_sys_in, // Clock
  input  wire logic [3:0] ss_n_in,    // Selects
  input  wire logic       sclk_in,    // Serial clock
  input  wire logic       mosi_in,    // To slave
  input  wire logic       cpol_in,    // Idle level
  input  wire logic       cpha_in,    // Phase
  output logic            miso_out,   // To master
  output logic [63:0]     cap_out,    // Sampled bits
  output int              cnt_out     // Sample count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_reg = 1'b0;
  logic junk_reg = 1'b0;
  initial cap_out = 64'h0;
  initial cnt_out = 0;
  always @(posedge clk_sys_in) begin
    sclk_reg <= sclk_in;
    junk_reg <= ~junk_reg;
    if (ss_n_in != 4'hf && sclk_in != sclk_reg && (sclk_in ^ cpol_in) != cpha_in) begin
      cap_out <= {cap_out[62:0], mosi_in};
      cnt_out <= cnt_out + 1;
    end
  end
  // Released line shows a changing pattern
  assign miso_out = (ss_n_in != 4'hf) ? mosi_in : junk_reg;
endmodule // smu_slave_model

// *** spi_master_unit_tb.sv ***
// Self-checking bench for the serial master unit
module spi_master_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smu_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        ce_in = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [63:0] wdata = 64'h0;
  logic [7:0]  be = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rdy = 1'b0;
  logic        stall = 1'b0;
  logic [3:0]  pwm = 4'h0;
  logic [1:0]  mode = 2'b00;
  logic        pv = 1'b0;
  logic [63:0] pd = 64'h0;
  logic [63:0] rdata, sdata, cap;
  logic        rvalid, svalid, sclk, mosi, miso;
  logic [3:0]  ss_n;
  int          cnt;
  int          fails = 0;
  int          cmp_count = 0;
  logic [63:0] rd_q[$];
  logic [63:0] st_q[$];
  logic [4:0]  ra [7] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h1f};
  always #25 clk_sys_in = ~clk_sys_in;
  smu_master DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_be_in(be), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .pwm_cycle_start_in(pwm[0]), .pwm_cycle_centre_in(pwm[1]), .pwm_mark_a_in(pwm[2]), .pwm_mark_b_in(pwm[3]),
    .miso_in(miso), .sclk_out(sclk), .mosi_out(mosi), .ss_n_out(ss_n), .rx_stream_valid_out(svalid),
    .rx_stream_data_out(sdata), .rx_stream_ready_in(rdy));
  smu_slave_model u_slave (.clk_sys_in(clk_sys_in), .ss_n_in(ss_n), .sclk_in(sclk), .mosi_in(mosi),
    .cpol_in(mode[1]), .cpha_in(mode[0]), .miso_out(miso), .cap_out(cap), .cnt_out(cnt));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d mismatched", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Handshake of the previous rising edge is judged here
  always @(negedge clk_sys_in) begin
    if (rvalid) check("read data", rdata, rd_q.size() ? rd_q.pop_front() : 64'hx);
    if (pv && rdy) check("stream word", pd, st_q.size() ? st_q.pop_front() : 64'hx);
    pv <= svalid;
    pd <= sdata;
    rdy <= !stall && ($urandom % 4 != 0);
  end
  task automatic wr_reg(input logic [4:0] a, input logic [63:0] d, input logic [7:0] b);
    @(negedge clk_sys_in);
    addr = a;
    wdata = d;
    be = b;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [63:0] e);
    @(negedge clk_sys_in);
    addr = a;
    rd = 1'b1;
    rd_q.push_back(e);
    @(negedge clk_sys_in);
    rd = 1'b0;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(negedge clk_sys_in);
    pwm = m;
    @(negedge clk_sys_in);
    pwm = 4'h0;
  endtask
  task automatic setup(input logic [15:0] c, input logic [5:0] s, input logic [7:0] p);
    wr_reg(SMU_REG_PERIOD, 64'(p), 8'hff);
    wr_reg(SMU_REG_SIZE, 64'(s), 8'hff);
    wr_reg(SMU_REG_CFG, 64'(c), 8'hff);
    mode = c[6:5];
  endtask
  // Entered half a cycle after the start edge; lag covers the soft trigger
  task automatic frame_end(input int n, input int h, input int lag, input logic [63:0] tx, input logic lsb);
    int c0;
    logic [63:0] m;
    logic [63:0] e;
    c0 = cnt;
    m = (n == 64) ? ~64'h0 : (64'h1 << n) - 64'h1;
    e = 64'h0;
    for (int i = 0; i < n; i++) e[i] = lsb ? tx[n-1-i] : tx[i];
    st_q.push_back(tx & m);
    rd_reg(SMU_REG_STATE, 64'h0);
    repeat ((2 * n + 1) * h + lag - 4) @(negedge clk_sys_in);
    rd_reg(SMU_REG_STATE, 64'h0);
    rd_reg(SMU_REG_STATE, 64'h1);
    rd_reg(SMU_REG_RX, tx & m);
    check("slave bits", cap & m, e);
    check("slave count", 64'(cnt - c0), 64'(n));
  endtask
  initial begin
    int seed;
    int n;
    int h;
    logic [15:0] c;
    logic [63:0] tx;
    logic [3:0] g;
    seed = $urandom(32'h643a);
    repeat (10) @(negedge clk_sys_in);
    reset_in = 1'b0;
    foreach (ra[i]) rd_reg(ra[i], 64'(ra[i] == SMU_REG_STATE));
    $display("Test reset values done");
    for (int i = 0; i < 12; i++) begin
      n = (i == 0) ? 64 : (i == 1) ? 1 : 1 + $urandom % 64;
      h = 2 + $urandom % 3;
      c = {9'h000, 3'(i), (i == 2), 1'b0, 2'($urandom)};
      tx = {$urandom, $urandom};
      setup(c, 6'(n - 1), 8'(h - 2));
      wr_reg(SMU_REG_TX, tx, ~(8'h01 << ((n - 1) / 8)));
      rd_reg(SMU_REG_STATE, 64'h1);
      wr_reg(SMU_REG_TX, tx, 8'h01 << ((n - 1) / 8));
      check("select", 64'(ss_n), 64'(4'(~(4'h1 << c[1:0]))));
      frame_end(n, h, 0, tx, c[4]);
      if (c[3]) begin
        check("kept select", 64'(ss_n), 64'(4'(~(4'h1 << c[1:0]))));
        wr_reg(SMU_REG_CFG, 64'(c & 16'hfff7), 8'hff);
        repeat (2) @(negedge clk_sys_in);
        check("released select", 64'(ss_n), 64'hf);
      end
    end
    $display("Test frames done");
    for (int t = 1; t < 8; t++) begin
      tx = {$urandom, $urandom};
      g = (t < 5) ? 4'h1 << (t - 1) : (t == 5) ? 4'h4 : 4'h0;
      setup(16'(t << 8), 6'h0f, 8'h00);
      wr_reg(SMU_REG_TX, tx, 8'hff);
      pulse((t < 5) ? ~g : (t == 5) ? 4'h3 : 4'hf);
      rd_reg(SMU_REG_STATE, 64'h1);
      if (t == 7) wr_reg(SMU_REG_CFG, 64'h8700, 8'hff);
      else pulse(g);
      if (t != 6) frame_end(16, 2, (t == 7) ? 1 : 0, tx, 1'b0);
    end
    rd_reg(SMU_REG_CFG, 64'h0700);
    rd_reg(SMU_REG_STATE, 64'h1);
    $display("Test triggers done");
    stall = 1'b1;
    setup(16'h0000, 6'h00, 8'h00);
    for (int k = 0; k < 10; k++) begin
      tx = 64'($urandom);
      wr_reg(SMU_REG_TX, tx, 8'h01);
      if (k < 9) st_q.push_back(tx & 64'h1);
      else check("blocked start", 64'(ss_n), 64'hf);
      repeat (10) @(negedge clk_sys_in);
    end
    rd_reg(SMU_REG_STATE, 64'h1);
    stall = 1'b0;
    for (int k = 0; k < 400 && st_q.size() != 0; k++) @(negedge clk_sys_in);
    repeat (4) @(negedge clk_sys_in);
    check("stream backlog", 64'(st_q.size() + rd_q.size()), 64'h0);
    $display("Test buffer fill done");
    report_and_stop();
  end
endmodule // spi_master_unit_tb
